// >>> logic/touch_gesture_classifier.sv
`include "gesture_params.svh"

module touch_gesture_classifier
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RSTN,
  // Frame data from the position decoder
  input  wire logic        FRAME_STROBE,
  input  wire logic        TOUCH_PRESENT,
  input  wire logic        LARGE_SIGNAL,
  input  wire logic [11:0] TOUCH_X,
  input  wire logic [11:0] TOUCH_Y,
  // Register port from the host interface
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [12:0] adiff(input logic [11:0] a, input logic [11:0] b);
    adiff = (a >= b) ? {1'b0, a - b} : {1'b0, b - a};
  endfunction

  function automatic logic beyond(input logic [12:0] d, input logic [7:0] lim);
    beyond = d > {5'h00, lim};
  endfunction

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] hlen_q, vlen_q, hold_lim_q, spread_q, spacing_q;
  logic [7:0] hold_lo_q, hold_hi_q, window_q, reverse_q, speed_q;
  logic [7:0] hangle_q, vangle_q;

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      hlen_q     <= `RST_SWIPE_LEN;
      vlen_q     <= `RST_SWIPE_LEN;
      hold_lim_q <= `RST_HOLD_MOVE_LIMIT;
      spread_q   <= `RST_CLICK_SPREAD;
      spacing_q  <= `RST_DCLICK_SPACING;
      hold_lo_q  <= `RST_HOLD_TIME_LO;
      hold_hi_q  <= `RST_HOLD_TIME_HI;
      window_q   <= `RST_DCLICK_WINDOW;
      reverse_q  <= `RST_REVERSE_LIMIT;
      speed_q    <= `RST_SWIPE_MIN_SPEED;
      hangle_q   <= `RST_ANGLE;
      vangle_q   <= `RST_ANGLE;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == `OFS_HORIZ_SWIPE_LEN) hlen_q <= REG_WDATA;
      else if (REG_ADDR == `OFS_VERT_SWIPE_LEN) vlen_q <= REG_WDATA;
      else if (REG_ADDR == `OFS_HOLD_MOVE_LIMIT) hold_lim_q <= REG_WDATA;
      else if (REG_ADDR == `OFS_CLICK_SPREAD) spread_q <= REG_WDATA;
      else if (REG_ADDR == `OFS_DCLICK_SPACING) spacing_q <= REG_WDATA;
      else if (REG_ADDR == `OFS_HOLD_TIME_LO) hold_lo_q <= REG_WDATA;
      else if (REG_ADDR == `OFS_HOLD_TIME_HI) hold_hi_q <= REG_WDATA;
      else if (REG_ADDR == `OFS_DCLICK_WINDOW) window_q <= REG_WDATA;
      else if (REG_ADDR == `OFS_REVERSE_LIMIT) reverse_q <= REG_WDATA;
      else if (REG_ADDR == `OFS_SWIPE_MIN_SPEED) speed_q <= REG_WDATA;
      else if (REG_ADDR == `OFS_HORIZ_ANGLE) hangle_q <= REG_WDATA;
      else if (REG_ADDR == `OFS_VERT_ANGLE) vangle_q <= REG_WDATA;
    end
  end

  // ----------------------------------------
  // Per-frame geometry
  // ----------------------------------------
  logic [11:0] start_x_q, start_y_q, prev_x_q, prev_y_q, tap_x_q, tap_y_q;
  logic [11:0] peak_q;
  logic        axis_x_q, dir_pos_q, second_q, spread_bad_q;
  logic [15:0] press_cnt_q;
  logic [7:0]  gap_cnt_q;
  gesture_pkg::state_t state_q;

  logic [12:0] dx, dy, fx, fy, tdx, tdy, major, minor, rev;
  logic [20:0] minor_scaled, major_scaled;
  logic        horiz, swipe_reached, angle_ok, cur_pos;
  logic [11:0] axis_cur;
  logic [7:0]  swipe_code, angle_lim;

  always_comb
  begin
    dx            = adiff(TOUCH_X, start_x_q);
    dy            = adiff(TOUCH_Y, start_y_q);
    fx            = adiff(TOUCH_X, prev_x_q);
    fy            = adiff(TOUCH_Y, prev_y_q);
    tdx           = adiff(start_x_q, tap_x_q);
    tdy           = adiff(start_y_q, tap_y_q);
    horiz         = dx >= dy;
    major         = horiz ? dx : dy;
    minor         = horiz ? dy : dx;
    swipe_reached = (dx >= {5'h00, hlen_q}) || (dy >= {5'h00, vlen_q});
    // Linear slope test keeps the angle check free of trig tables.
    angle_lim     = horiz ? hangle_q : vangle_q;
    minor_scaled  = 21'(minor) * `ANGLE_FULL;
    major_scaled  = 21'(major) * 21'(angle_lim);
    angle_ok      = minor_scaled <= major_scaled;
    cur_pos       = horiz ? (TOUCH_X > start_x_q) : (TOUCH_Y > start_y_q);
    // Right and down are the increasing channel directions.
    if (horiz)
      swipe_code = cur_pos ? `GC_SWIPE_RIGHT : `GC_SWIPE_LEFT;
    else
      swipe_code = cur_pos ? `GC_SWIPE_DOWN : `GC_SWIPE_UP;
    axis_cur      = axis_x_q ? TOUCH_X : TOUCH_Y;
    if (dir_pos_q)
      rev = (peak_q > axis_cur) ? {1'b0, peak_q - axis_cur} : 13'h0000;
    else
      rev = (axis_cur > peak_q) ? {1'b0, axis_cur - peak_q} : 13'h0000;
  end

  // ----------------------------------------
  // Gesture state machine
  // ----------------------------------------
  logic       report_d;
  logic [7:0] report_code_d;
  logic       diag_d;
  logic [7:0] diag_code_d;

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_q     <= gesture_pkg::ST_IDLE;
      start_x_q   <= 12'h000;
      start_y_q   <= 12'h000;
      prev_x_q    <= 12'h000;
      prev_y_q    <= 12'h000;
      tap_x_q     <= 12'h000;
      tap_y_q     <= 12'h000;
      peak_q      <= 12'h000;
      axis_x_q    <= 1'b0;
      dir_pos_q   <= 1'b0;
      second_q    <= 1'b0;
      spread_bad_q <= 1'b0;
      press_cnt_q <= 16'h0000;
      gap_cnt_q   <= 8'h00;
      report_d    <= 1'b0;
      report_code_d <= `GC_NONE;
      diag_d      <= 1'b0;
      diag_code_d <= 8'h00;
    end
    else
    begin
      report_d <= 1'b0;
      diag_d   <= 1'b0;
      if (FRAME_STROBE)
      begin
        prev_x_q <= TOUCH_X;
        prev_y_q <= TOUCH_Y;
        case (state_q)
          gesture_pkg::ST_IDLE:
          begin
            second_q <= 1'b0;
            spread_bad_q <= 1'b0;
            if (TOUCH_PRESENT)
            begin
              start_x_q   <= TOUCH_X;
              start_y_q   <= TOUCH_Y;
              press_cnt_q <= 16'h0000;
              state_q     <= gesture_pkg::ST_PRESS;
            end
          end
          gesture_pkg::ST_PRESS:
          begin
            if (!TOUCH_PRESENT)
            begin
              if (spread_bad_q)
                state_q <= gesture_pkg::ST_IDLE;
              else if (second_q && !beyond(tdx, spacing_q) && !beyond(tdy, spacing_q))
              begin
                report_d      <= 1'b1;
                report_code_d <= `GC_DOUBLE;
                state_q       <= gesture_pkg::ST_IDLE;
              end
              else
              begin
                // A lone tap waits for a possible second one.
                tap_x_q   <= start_x_q;
                tap_y_q   <= start_y_q;
                gap_cnt_q <= 8'h00;
                second_q  <= 1'b0;
                state_q   <= gesture_pkg::ST_GAP;
              end
            end
            else if (swipe_reached)
            begin
              if (angle_ok)
              begin
                axis_x_q      <= horiz;
                dir_pos_q     <= cur_pos;
                peak_q        <= horiz ? TOUCH_X : TOUCH_Y;
                report_code_d <= swipe_code;
                state_q       <= gesture_pkg::ST_SWIPE;
              end
              else
              begin
                diag_d      <= 1'b1;
                diag_code_d <= `DG_OUTSIDE_ANGLE;
                state_q     <= gesture_pkg::ST_DRAIN;
              end
            end
            else if (!spread_bad_q && (beyond(dx, spread_q) || beyond(dy, spread_q)))
            begin
              // Only the click is voided: the press may still travel far enough to swipe.
              diag_d       <= 1'b1;
              diag_code_d  <= `DG_CLICK_THRESH;
              spread_bad_q <= 1'b1;
            end
            else if (!spread_bad_q && press_cnt_q + 16'h0001 >= {hold_hi_q, hold_lo_q})
            begin
              report_d      <= 1'b1;
              report_code_d <= `GC_CLICK_HOLD;
              state_q       <= gesture_pkg::ST_DRAIN;
            end
            else
              press_cnt_q <= press_cnt_q + 16'h0001;
          end
          gesture_pkg::ST_GAP:
          begin
            if (TOUCH_PRESENT)
            begin
              start_x_q   <= TOUCH_X;
              start_y_q   <= TOUCH_Y;
              press_cnt_q <= 16'h0000;
              second_q    <= 1'b1;
              state_q     <= gesture_pkg::ST_PRESS;
            end
            else if (gap_cnt_q >= window_q)
            begin
              report_d      <= 1'b1;
              report_code_d <= `GC_CLICK;
              diag_d        <= 1'b1;
              diag_code_d   <= `DG_CLICK_TIMEOUT;
              state_q       <= gesture_pkg::ST_IDLE;
            end
            else
              gap_cnt_q <= gap_cnt_q + 8'h01;
          end
          gesture_pkg::ST_SWIPE:
          begin
            if (!TOUCH_PRESENT)
            begin
              report_d <= 1'b1;
              state_q  <= gesture_pkg::ST_IDLE;
            end
            else if (beyond(rev, reverse_q))
            begin
              diag_d      <= 1'b1;
              diag_code_d <= `DG_REVERSE_THRESH;
              state_q     <= gesture_pkg::ST_DRAIN;
            end
            else if (fx < {5'h00, speed_q} && fy < {5'h00, speed_q})
            begin
              report_d      <= 1'b1;
              report_code_d <= report_code_d + 8'h01;
              start_x_q     <= TOUCH_X;
              start_y_q     <= TOUCH_Y;
              state_q       <= gesture_pkg::ST_HOLD;
            end
            else if ((dir_pos_q && axis_cur > peak_q) || (!dir_pos_q && axis_cur < peak_q))
              peak_q <= axis_cur;
          end
          gesture_pkg::ST_HOLD:
          begin
            if (!TOUCH_PRESENT)
              state_q <= gesture_pkg::ST_IDLE;
            else if (beyond(dx, hold_lim_q) || beyond(dy, hold_lim_q))
            begin
              diag_d      <= 1'b1;
              diag_code_d <= `DG_HOLD_VALUE;
              state_q     <= gesture_pkg::ST_DRAIN;
            end
          end
          default:
          begin
            if (!TOUCH_PRESENT)
              state_q <= gesture_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Reported registers
  // ----------------------------------------
  logic [7:0] gesture_code_q, diag_q;
  logic       gesture_flag_q;
  logic       code_read;

  assign code_read = REG_RD && (REG_ADDR == `OFS_GESTURE_CODE);

  // A gesture finishing in the read cycle wins over the read's clear.
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      gesture_code_q <= `GC_NONE;
      gesture_flag_q <= 1'b0;
    end
    else if (report_d)
    begin
      gesture_code_q <= report_code_d;
      gesture_flag_q <= 1'b1;
    end
    else if (code_read)
    begin
      gesture_code_q <= `GC_NONE;
      gesture_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      diag_q <= 8'h00;
    else if (diag_d)
      diag_q <= diag_code_d;
    else if (REG_WR && REG_ADDR == `OFS_GESTURE_DIAG)
      diag_q <= REG_WDATA;
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      REG_RDATA <= 8'h00;
    else if (REG_RD)
    begin
      if (REG_ADDR == `OFS_TOUCH_STATUS)
      begin
        REG_RDATA <= 8'h00;
        REG_RDATA[`BIT_TOUCH_PRESENT] <= TOUCH_PRESENT;
        REG_RDATA[`BIT_GESTURE_FLAG] <= gesture_flag_q;
        REG_RDATA[`BIT_LARGE_SIGNAL] <= LARGE_SIGNAL;
      end
      else if (REG_ADDR == `OFS_GESTURE_CODE) REG_RDATA <= gesture_code_q;
      else if (REG_ADDR == `OFS_GESTURE_DIAG) REG_RDATA <= diag_q;
      else if (REG_ADDR == `OFS_HORIZ_SWIPE_LEN) REG_RDATA <= hlen_q;
      else if (REG_ADDR == `OFS_VERT_SWIPE_LEN) REG_RDATA <= vlen_q;
      else if (REG_ADDR == `OFS_HOLD_MOVE_LIMIT) REG_RDATA <= hold_lim_q;
      else if (REG_ADDR == `OFS_CLICK_SPREAD) REG_RDATA <= spread_q;
      else if (REG_ADDR == `OFS_DCLICK_SPACING) REG_RDATA <= spacing_q;
      else if (REG_ADDR == `OFS_HOLD_TIME_LO) REG_RDATA <= hold_lo_q;
      else if (REG_ADDR == `OFS_HOLD_TIME_HI) REG_RDATA <= hold_hi_q;
      else if (REG_ADDR == `OFS_DCLICK_WINDOW) REG_RDATA <= window_q;
      else if (REG_ADDR == `OFS_REVERSE_LIMIT) REG_RDATA <= reverse_q;
      else if (REG_ADDR == `OFS_SWIPE_MIN_SPEED) REG_RDATA <= speed_q;
      else if (REG_ADDR == `OFS_HORIZ_ANGLE) REG_RDATA <= hangle_q;
      else if (REG_ADDR == `OFS_VERT_ANGLE) REG_RDATA <= vangle_q;
      else REG_RDATA <= 8'h00;
    end
  end

endmodule

// >>> logic/gesture_params.svh
`ifndef GESTURE_PARAMS_SVH
`define GESTURE_PARAMS_SVH
// What this block does
// - On a recognised gesture, store its code and set the gesture flag.
// - Host read of the gesture code clears both code and gesture flag.
// - Diagnostic register holds the latest diagnostic code raised or host write to it; a gesture that raises none leaves it unchanged.
// - Codes: 00 none, 10 click, 11 click-hold, 20 double, swipes 31/41/51/61, hold +1.
// - Increasing X is right, increasing Y is down.
// - Diagnostic codes 01..07, 09, 0A as listed; 08 reserved.
// - Swipe needs travel from touchdown of at least horizontal or vertical length.
// - Swipe cancelled when reverse movement exceeds the reverse limit.
// - Swipe becomes hold when frame movement falls below minimum speed.
// - Swipes outside the angle limit are detected but not reported.
// - In swipe hold, movement must stay within the hold limit.
// - Double click needs both taps within the tap spacing distance.
// - All points of a click must stay within the click spread limit.
// - Click held for the 16-bit hold time becomes click-and-hold.
// - Double click needs the gap not above the double click window.

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_TOUCH_STATUS     8'h10
`define OFS_GESTURE_CODE     8'h14
`define OFS_GESTURE_DIAG     8'h15
`define OFS_HORIZ_SWIPE_LEN  8'h37
`define OFS_VERT_SWIPE_LEN   8'h38
`define OFS_HOLD_MOVE_LIMIT  8'h39
`define OFS_CLICK_SPREAD     8'h3A
`define OFS_DCLICK_SPACING   8'h3B
`define OFS_HOLD_TIME_LO     8'h3C
`define OFS_HOLD_TIME_HI     8'h3D
`define OFS_DCLICK_WINDOW    8'h3E
`define OFS_REVERSE_LIMIT    8'h3F
`define OFS_SWIPE_MIN_SPEED  8'h40
`define OFS_HORIZ_ANGLE      8'h41
`define OFS_VERT_ANGLE       8'h42

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_SWIPE_LEN        8'h40
`define RST_HOLD_MOVE_LIMIT  8'h19
`define RST_CLICK_SPREAD     8'h19
`define RST_DCLICK_SPACING   8'h40
`define RST_HOLD_TIME_LO     8'h32
`define RST_HOLD_TIME_HI     8'h00
`define RST_DCLICK_WINDOW    8'h0C
`define RST_REVERSE_LIMIT    8'h20
`define RST_SWIPE_MIN_SPEED  8'h04
`define RST_ANGLE            8'h2D

// ----------------------------------------
// Field positions of touch_status
// ----------------------------------------
`define BIT_TOUCH_PRESENT    0
`define BIT_GESTURE_FLAG     1
`define BIT_LARGE_SIGNAL     2

// ----------------------------------------
// Gesture and diagnostic codes
// ----------------------------------------
`define GC_NONE              8'h00
`define GC_CLICK             8'h10
`define GC_CLICK_HOLD        8'h11
`define GC_DOUBLE            8'h20
`define GC_SWIPE_DOWN        8'h31
`define GC_SWIPE_RIGHT       8'h41
`define GC_SWIPE_UP          8'h51
`define GC_SWIPE_LEFT        8'h61
`define DG_CLICK_TIMEOUT     8'h01
`define DG_SWIPE_TIMEOUT     8'h02
`define DG_GENERAL_TIMEOUT   8'h03
`define DG_CLICK_THRESH      8'h04
`define DG_SWIPE_THRESH      8'h05
`define DG_SWIPE_HOLD_THRESH 8'h06
`define DG_REVERSE_THRESH    8'h07
`define DG_HOLD_VALUE        8'h09
`define DG_OUTSIDE_ANGLE     8'h0A

// Full-scale angle used by the linear slope test.
`define ANGLE_FULL           21'h00002D
`endif

// >>> logic/gesture_pkg.sv
package gesture_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_PRESS = 6'b000010,
    ST_GAP   = 6'b000100,
    ST_SWIPE = 6'b001000,
    ST_HOLD  = 6'b010000,
    ST_DRAIN = 6'b100000
  } state_t;
endpackage

// >>> sim/touch_gesture_assertions.sv
`include "gesture_params.svh"

module touch_gesture_assertions
(
  // Clock and reset
  input wire logic       REF_CLK,
  input wire logic       RSTN,
  // Frame link
  input wire logic       FRAME_STROBE,
  input wire logic       TOUCH_PRESENT,
  input wire logic       LARGE_SIGNAL,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] strobe_q;
  logic [7:0] wa_q;
  logic [7:0] wd_q;
  logic       diag_wr_q;
  logic       quiet;
  logic       cfg;
  logic       mapped;

  // A gesture may land between two reads only if a frame was near them.
  assign quiet  = !FRAME_STROBE && (strobe_q == 4'h0);
  assign cfg    = (REG_ADDR >= `OFS_HORIZ_SWIPE_LEN) && (REG_ADDR <= `OFS_VERT_ANGLE);
  assign mapped = cfg || (REG_ADDR inside {8'h10, 8'h14, 8'h15});

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      strobe_q  <= 4'h0;
      wa_q      <= 8'h00;
      wd_q      <= 8'h00;
      diag_wr_q <= 1'b0;
    end
    else
    begin
      strobe_q  <= {strobe_q[2:0], FRAME_STROBE};
      wa_q      <= REG_WR ? REG_ADDR : wa_q;
      wd_q      <= REG_WR ? REG_WDATA : wd_q;
      diag_wr_q <= diag_wr_q | (REG_WR && REG_ADDR == 8'h15);
    end
  end

  reset_rdata_a: assert property ($rose(RSTN) |-> REG_RDATA == 8'h00)
    else $error("read data not zero after reset");
  unmapped_read_a: assert property (REG_RD && !mapped |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  status_live_a: assert property (REG_RD && REG_ADDR == 8'h10 |=>
    REG_RDATA[0] == $past(TOUCH_PRESENT) && REG_RDATA[2] == $past(LARGE_SIGNAL) && REG_RDATA[7:3] == 5'h00)
    else $error("status bits wrong");
  rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without read");
  code_clear_a: assert property (REG_RD && REG_ADDR == 8'h14 ##2 REG_RD && REG_ADDR == 8'h14 && quiet
    |=> REG_RDATA == 8'h00)
    else $error("gesture code not cleared by read");
  flag_clear_a: assert property (REG_RD && REG_ADDR == 8'h14 ##2 REG_RD && REG_ADDR == 8'h10 && quiet
    |=> REG_RDATA[1] == 1'b0)
    else $error("gesture flag not cleared by read");
  code_legal_a: assert property (REG_RD && REG_ADDR == 8'h14 |=> REG_RDATA inside
    {8'h00, 8'h10, 8'h11, 8'h20, 8'h31, 8'h32, 8'h41, 8'h42, 8'h51, 8'h52, 8'h61, 8'h62})
    else $error("illegal gesture code");
  diag_legal_a: assert property (REG_RD && REG_ADDR == 8'h15 && !diag_wr_q |=>
    REG_RDATA inside {[8'h00:8'h07], 8'h09, 8'h0A})
    else $error("illegal diagnostic code");
  config_echo_a: assert property (REG_RD && !REG_WR && cfg && REG_ADDR == wa_q |=> REG_RDATA == wd_q)
    else $error("config read back wrong");

  cover property (REG_RD && REG_ADDR == 8'h14 ##1 REG_RDATA == 8'h20);
  cover property (REG_RD && REG_ADDR == 8'h14 ##1 REG_RDATA == 8'h32);
  cover property (REG_RD && REG_ADDR == 8'h15 ##1 REG_RDATA == 8'h0A);
endmodule

// >>> sim/gesture_host.sv
module gesture_host
(
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // Released lines show the inverse, so nothing rides on a stale value.
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// >>> sim/tb_touch_gesture_classifier.sv
module tb_touch_gesture_classifier;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        frame_strobe = 1'b0;
  logic        touch_present = 1'b0;
  logic        large_signal = 1'b0;
  logic [11:0] touch_x = 12'h000;
  logic [11:0] touch_y = 12'h000;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  int          seed = 79776;
  int          failures = 0;
  int          checks_done = 0;
  logic [7:0]  cfg_rst [12] = '{8'h40, 8'h40, 8'h19, 8'h19, 8'h40, 8'h32, 8'h00, 8'h0C, 8'h20, 8'h04, 8'h2D, 8'h2D};
  logic [7:0]  zero_addr [5] = '{8'h14, 8'h15, 8'h00, 8'h16, 8'hFF};

  always #10 ref_clk = ~ref_clk;

  touch_gesture_classifier touch_gesture_classifier_i
  (
    .REF_CLK       (ref_clk),
    .RSTN          (rstn),
    .FRAME_STROBE  (frame_strobe),
    .TOUCH_PRESENT (touch_present),
    .LARGE_SIGNAL  (large_signal),
    .TOUCH_X       (touch_x),
    .TOUCH_Y       (touch_y),
    .REG_ADDR      (reg_addr),
    .REG_WDATA     (reg_wdata),
    .REG_WR        (reg_wr),
    .REG_RD        (reg_rd),
    .REG_RDATA     (reg_rdata)
  );

  gesture_host gesture_host_i
  (
    .clk       (ref_clk),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic give_verdict;
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] swipe_code(input int dx, input int dy);
    if ((dx < 0 ? -dx : dx) >= (dy < 0 ? -dy : dy))
      return dx > 0 ? 8'h41 : 8'h61;
    return dy > 0 ? 8'h31 : 8'h51;
  endfunction

  // A diag of FF means the diagnostic is not checked.
  task automatic expect_gesture(input logic [7:0] code, input logic [7:0] diag);
    logic [7:0] d;
    gesture_host_i.reg_read(8'h10, d);
    check({7'h00, d[1]}, {7'h00, code != 8'h00});
    gesture_host_i.reg_read(8'h14, d);
    check(d, code);
    gesture_host_i.reg_read(8'h14, d);
    check(d, 8'h00);
    gesture_host_i.reg_read(8'h10, d);
    check({7'h00, d[1]}, 8'h00);
    gesture_host_i.reg_read(8'h15, d);
    if (diag !== 8'hFF)
      check(d, diag);
  endtask

  // ----------------------------------------
  // Frame stimulus
  // ----------------------------------------
  task automatic frame(input logic t, input int x, input int y);
    @(posedge ref_clk);
    frame_strobe  <= 1'b1;
    touch_present <= t;
    large_signal  <= 1'($random(seed));
    touch_x       <= 12'(x);
    touch_y       <= 12'(y);
    @(posedge ref_clk);
    frame_strobe <= 1'b0;
    touch_x      <= ~12'(x);
    touch_y      <= ~12'(y);
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic idle(input int n);
    repeat (n) frame(1'b0, $random(seed), $random(seed));
  endtask

  task automatic tap(input int x, input int y);
    frame(1'b1, x, y);
    frame(1'b1, x + 2, y + 1);
    frame(1'b0, x, y);
  endtask

  // Four equal steps from a random start, optional still frames, an optional jump, then lift.
  task automatic swipe(input int dx, input int dy, input int hold, input int jump);
    int x0;
    int y0;
    x0 = 1000 + ($random(seed) & 255);
    y0 = 1000 + ($random(seed) & 255);
    for (int i = 0; i <= 4; i++)
      frame(1'b1, x0 + i * dx / 4, y0 + i * dy / 4);
    repeat (hold) frame(1'b1, x0 + dx, y0 + dy);
    if (jump != 0)
      frame(1'b1, x0 + dx + jump, y0 + dy);
    frame(1'b0, x0 + dx, y0 + dy);
    idle(4);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] d;
    int         dx;
    int         dy;
    int         mj;
    int         mn;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (cfg_rst[i])
    begin
      gesture_host_i.reg_read(8'h37 + 8'(i), d);
      check(d, cfg_rst[i]);
    end
    gesture_host_i.reg_write(8'h14, 8'h55);
    gesture_host_i.reg_write(8'h16, 8'hA5);
    foreach (zero_addr[i])
    begin
      gesture_host_i.reg_read(zero_addr[i], d);
      check(d, 8'h00);
    end
    tap(600, 700);
    idle(16);
    expect_gesture(8'h10, 8'h01);
    tap(800, 500);
    idle(3);
    tap(810, 500);
    idle(16);
    expect_gesture(8'h20, 8'hFF);
    frame(1'b1, 400, 400);
    frame(1'b1, 430, 400);
    frame(1'b0, 430, 400);
    idle(16);
    expect_gesture(8'h00, 8'h04);
    for (int k = 0; k < 4; k++)
    begin
      mj = 64 + ($random(seed) & 15);
      mn = $random(seed) & 15;
      dx = (k == 1) ? mj : (k == 3) ? -mj : mn;
      dy = (k == 0) ? mj : (k == 2) ? -mj : mn;
      swipe(dx, dy, 0, 0);
      expect_gesture(swipe_code(dx, dy), 8'h04);
    end
    swipe(0, 80, 2, 40);
    expect_gesture(8'h32, 8'h09);
    swipe(80, 0, 0, -40);
    expect_gesture(8'h00, 8'h07);
    gesture_host_i.reg_write(8'h41, 8'h14);
    gesture_host_i.reg_write(8'h42, 8'h14);
    gesture_host_i.reg_read(8'h42, d);
    check(d, 8'h14);
    swipe(80, 60, 0, 0);
    expect_gesture(8'h00, 8'h0A);
    gesture_host_i.reg_write(8'h41, 8'h2D);
    gesture_host_i.reg_write(8'h42, 8'h2D);
    gesture_host_i.reg_write(8'h3C, 8'h05);
    repeat (8) frame(1'b1, 900, 900);
    frame(1'b0, 900, 900);
    idle(16);
    expect_gesture(8'h11, 8'hFF);
    give_verdict();
  end

  // The whole run needs well under 10000 cycles.
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    failures++;
    give_verdict();
  end
endmodule

bind touch_gesture_classifier touch_gesture_assertions touch_gesture_assertions_i
(
  .REF_CLK       (REF_CLK),
  .RSTN          (RSTN),
  .FRAME_STROBE  (FRAME_STROBE),
  .TOUCH_PRESENT (TOUCH_PRESENT),
  .LARGE_SIGNAL  (LARGE_SIGNAL),
  .REG_ADDR      (REG_ADDR),
  .REG_WDATA     (REG_WDATA),
  .REG_WR        (REG_WR),
  .REG_RD        (REG_RD),
  .REG_RDATA     (REG_RDATA)
);
